/* File: rtl/ehc_pkg.sv */
// Purpose: shared constants for the serial command port
// Assumes: 20 MHz core clock, byte-wide command codes
// Notes: command codes double as register offsets
package ehc_pkg;
    localparam logic [7:0] CMD_GATE_DRV_OUT = 8'h01;
    localparam logic [7:0] CMD_GATE_LEVEL = 8'h03;
    localparam logic [7:0] CMD_SOURCE_LEVEL = 8'h04;
    // values after reset
    localparam logic [7:0] SRC_HI1_RESET = 8'h41;
    localparam logic [7:0] SRC_HI2_RESET = 8'ha8;
    localparam logic [7:0] SRC_LO_RESET = 8'h32;
    localparam logic [23:0] GATE_OUT_RESET = 24'h000000;
    localparam logic [7:0] GATE_LEVEL_RESET = 8'h00;
    // field positions, word lengths and counter reset values
    localparam int SRC_LO_MSB = 7;
    localparam int BYTE_BITS = 8;
    localparam int WORD3_BITS = 9;
    localparam logic [1:0] PARAM_IDX_RESET = 2'h0;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    typedef enum logic [1:0] {
        EHC_ST_IDLE = 2'b00,
        EHC_ST_PARAMS = 2'b01,
        EHC_ST_IGNORE = 2'b10
    } ehc_state_t;
endpackage

/* File: rtl/ehc_byte_if.sv */
// Purpose: carries received bytes from the deserialiser to the decoder
// Assumes: one clock domain
// Notes: valid is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface ehc_byte_if;
    logic valid;
    logic is_data;
    logic [7:0] data;
    modport src (output valid, output is_data, output data);
    modport dst (input valid, input is_data, input data);
endinterface
`default_nettype wire

/* File: rtl/ehc_shifter.sv */
// Purpose: serial deserialiser for 3-line and 4-line framing
// Assumes: pins already synchronised by the caller
// Notes: sampling is on a detected rising serial clock edge
`timescale 1ns/1ps
`default_nettype none
module ehc_shifter (
    // clock and control
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // synchronised pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic dc,
    input wire logic three_line,
    // received bytes
    ehc_byte_if.src out
);
    import ehc_pkg::*;
    logic sclk_d, next_sclk_d;
    logic [8:0] shreg, next_shreg;
    logic [3:0] bitcnt, next_bitcnt;
    logic next_valid, next_is_data;
    logic [7:0] next_data;
    logic [3:0] word_len;
    logic rise;

    assign word_len = three_line ? 4'(WORD3_BITS) : 4'(BYTE_BITS); // R06
    assign rise = sclk & ~sclk_d; // R13

    // shift msb first; cs high clears the partial word
    always_comb begin
        next_sclk_d = sclk;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_valid = 1'b0;
        next_is_data = out.is_data;
        next_data = out.data;
        if (cs_n) begin
            next_bitcnt = BIT_CNT_RESET; // R01
        end else if (rise) begin
            next_shreg = {shreg[7:0], sdata}; // R13
            if (bitcnt == word_len - 4'h1) begin
                next_bitcnt = BIT_CNT_RESET;
                next_valid = 1'b1;
                next_data = {shreg[6:0], sdata};
                // 3-line: first bit carries data/command flag
                next_is_data = three_line ? shreg[7] : dc; // R02 R06
            end else begin
                next_bitcnt = bitcnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclk_d <= 1'b0;
            shreg <= 9'h000;
            bitcnt <= BIT_CNT_RESET;
            out.valid <= 1'b0;
            out.is_data <= 1'b0;
            out.data <= 8'h00;
        end else if (clk_en) begin
            sclk_d <= next_sclk_d;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            out.valid <= next_valid;
            out.is_data <= next_is_data;
            out.data <= next_data;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/ehc_top.sv */
// Purpose: host serial command port capturing drive level settings
// Assumes: host keeps pin timing slow against the 20 MHz core clock
// Notes: waveform and sensor engines sit outside; they report activity
//        on two level inputs that are echoed on busy a clock later
// Operation
// R01: chip select low enables transfers; high makes the port ignore the bus
// R02: data/command line high marks parameter bytes, low marks commands
// R03: hardware reset input is active low and resets the logic
// R04: host sends nothing while busy is high
// R05: busy is high during waveform output and temperature sensor traffic
// R06: strap low selects 4-line framing, high selects 9-bit 3-line framing
// R07: command 04 takes three bytes: high level one, two, low level
// R08: first source parameter resets to 41h, 15V
// R09: second source parameter resets to A8h, 5V
// R10: third source parameter resets to 32h, -15V
// R11: low level code keeps its top bit at zero
// R12: parameters fill fields in arrival order until next command
// R13: 4-line bytes shift msb first, sampled on rising serial clock

`timescale 1ns/1ps
`default_nettype none
module ehc_top (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // host pins
    input wire logic hw_reset_n,
    input wire logic cs_n,
    input wire logic dc_sel,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic serial_width_strap,
    // activity from display engines
    input wire logic waveform_active,
    input wire logic temp_sensor_active,
    // outputs
    output logic busy,
    output logic [7:0] source_high_level_one,
    output logic [7:0] source_high_level_two,
    output logic [7:0] source_low_level,
    output logic [23:0] gate_driver_output_setup,
    output logic [7:0] gate_high_level_select
);
    import ehc_pkg::*;
    // two-stage synchronisers for every host pin
    logic [5:0] sync1, sync2;
    logic [5:0] next_sync1, next_sync2;
    // pin values after the second stage
    logic hw_reset_sync_n, cs_sync_n, dc_sync;
    logic sclk_sync, sdata_sync, strap_sync;
    logic srst_n;
    ehc_byte_if rx ();
    ehc_state_t state, next_state;
    logic [7:0] cmd, next_cmd;
    logic [1:0] pidx, next_pidx;
    logic [7:0] next_hi1, next_hi2, next_lo, next_gl;
    logic [23:0] next_go;
    logic next_busy;

    // commands whose parameter bytes are kept; others are skipped
    function automatic logic known_cmd(input logic [7:0] code);
        unique case (code)
            CMD_SOURCE_LEVEL, CMD_GATE_DRV_OUT,
            CMD_GATE_LEVEL: known_cmd = 1'b1;
            default: known_cmd = 1'b0;
        endcase
    endfunction

    // index of the final parameter byte of a kept command
    function automatic logic [1:0] last_index(input logic [7:0] code);
        unique case (code)
            CMD_GATE_LEVEL: last_index = 2'h0;
            default: last_index = 2'h2;
        endcase
    endfunction

    // pin order: reset, cs, dc, sclk, sdata, strap
    always_comb begin
        next_sync1 = {serial_width_strap, sdata, sclk, dc_sel, cs_n,
                      hw_reset_n};
        next_sync2 = sync1;
    end

    // idle levels: select and host reset high, the rest low
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1 <= 6'h03;
            sync2 <= 6'h03;
        end else if (clk_en) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
        end
    end

    // only the second stage is read; the first may still be settling
    assign hw_reset_sync_n = sync2[0];
    assign cs_sync_n = sync2[1];
    assign dc_sync = sync2[2];
    assign sclk_sync = sync2[3];
    assign sdata_sync = sync2[4];
    assign strap_sync = sync2[5];

    // either reset source clears the port
    assign srst_n = resetn & hw_reset_sync_n; // R03

    // deserialiser sees the pins only after both stages
    ehc_shifter u_shift (
        .clk(clk),
        .resetn(srst_n),
        .clk_en(clk_en),
        .cs_n(cs_sync_n),
        .sclk(sclk_sync),
        .sdata(sdata_sync),
        .dc(dc_sync),
        .three_line(strap_sync),
        .out(rx)
    );

    // command tracking: a command opens a run, its last byte closes it
    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_pidx = pidx;
        if (rx.valid && !rx.is_data) begin
            next_cmd = rx.data; // R02 R12
            // a run restarts at index zero on every command
            next_pidx = PARAM_IDX_RESET;
            // unknown codes park the decoder until the next command
            if (known_cmd(rx.data)) begin
                next_state = EHC_ST_PARAMS;
            end else begin
                next_state = EHC_ST_IGNORE;
            end
        end else if (rx.valid && state == EHC_ST_PARAMS) begin
            next_pidx = pidx + 2'h1; // R12
            // extra bytes after the final one are dropped
            if (pidx == last_index(cmd)) begin
                next_state = EHC_ST_IGNORE; // R12
            end
        end
    end

    // fields: each data byte of a run lands by its arrival index
    always_comb begin
        next_hi1 = source_high_level_one;
        next_hi2 = source_high_level_two;
        next_lo = source_low_level;
        next_go = gate_driver_output_setup;
        next_gl = gate_high_level_select;
        if (rx.valid && rx.is_data && state == EHC_ST_PARAMS) begin
            unique case (cmd)
                CMD_SOURCE_LEVEL: begin
                    unique case (pidx)
                        2'h0: next_hi1 = rx.data; // R07
                        2'h1: next_hi2 = rx.data; // R07
                        default: begin
                            // top bit forced clear; sign is implied
                            next_lo = {1'b0, rx.data[SRC_LO_MSB-1:0]}; // R11
                        end
                    endcase
                end
                // gate outputs arrive low byte first
                CMD_GATE_DRV_OUT: begin
                    unique case (pidx)
                        2'h0: next_go[7:0] = rx.data;
                        2'h1: next_go[15:8] = rx.data;
                        default: next_go[23:16] = rx.data;
                    endcase
                end
                // only the gate level code is left; it takes one byte
                default: next_gl = rx.data;
            endcase
        end
    end

    // busy is a registered echo of engine activity; host must wait
    always_comb begin
        next_busy = waveform_active | temp_sensor_active; // R05 R04
    end

    // command tracking state
    always_ff @(posedge clk) begin
        if (!srst_n) begin
            state <= EHC_ST_IDLE; // R03
            cmd <= 8'h00;
            pidx <= PARAM_IDX_RESET;
        end else if (clk_en) begin
            state <= next_state;
            cmd <= next_cmd;
            pidx <= next_pidx;
        end
    end

    // captured fields; reset values are the power-on levels
    always_ff @(posedge clk) begin
        if (!srst_n) begin
            source_high_level_one <= SRC_HI1_RESET; // R08
            source_high_level_two <= SRC_HI2_RESET; // R09
            source_low_level <= SRC_LO_RESET; // R10
            gate_driver_output_setup <= GATE_OUT_RESET;
            gate_high_level_select <= GATE_LEVEL_RESET;
        end else if (clk_en) begin
            source_high_level_one <= next_hi1;
            source_high_level_two <= next_hi2;
            source_low_level <= next_lo;
            gate_driver_output_setup <= next_go;
            gate_high_level_select <= next_gl;
        end
    end

    // busy restarts low on either reset, then follows the engines
    always_ff @(posedge clk) begin
        if (!srst_n) begin
            busy <= 1'b0;
        end else if (clk_en) begin
            busy <= next_busy; // R05
        end
    end
endmodule
`default_nettype wire

/* File: dv/ehc_host_model.sv */
// Purpose: host side of the serial command pins
// Assumes: pins change just after clk rising edges
// Notes: data line shows inverse of last bit when idle
`timescale 1ns/1ps
`default_nettype none
module ehc_host_model (
    // clock and status
    input wire logic clk,
    input wire logic strap,
    input wire logic busy,
    // serial pins
    output logic cs_n = 1'b1,
    output logic dc_sel = 1'b0,
    output logic sclk = 1'b0,
    output logic sdata = 1'b0
);
    // m: 0 whole word, 1 cut after four bits, 2 select kept high
    task automatic send(input logic d, input logic [7:0] b, input int m);
        logic [8:0] w;
        int k;
        int lim;
        w = {d, b};
        k = strap ? 8 : 7;
        lim = (m == 1) ? k - 3 : 0;
        while (busy) @(posedge clk);
        @(posedge clk);
        cs_n <= (m == 2);
        // pin inverted in 3-line mode so only the flag bit can count
        dc_sel <= strap ? ~d : d;
        for (int i = k; i >= lim; i--) begin
            @(posedge clk) sdata <= w[i];
            repeat (3) @(posedge clk);
            sclk <= 1;
            repeat (3) @(posedge clk);
            sclk <= 0;
        end
        repeat (3) @(posedge clk);
        cs_n <= 1;
        sdata <= ~sdata;
    endtask
endmodule
`default_nettype wire

/* File: dv/ehc_top_sva.sv */
// Purpose: pin-level checks on the command port
// Assumes: one clock, resetn synchronous
// Notes: hw reset lands after its sync lag
`timescale 1ns/1ps
`default_nettype none
module ehc_top_sva (
    // clock and resets
    input wire logic clk,
    input wire logic resetn,
    input wire logic hw_reset_n,
    // watched pins
    input wire logic cs_n,
    input wire logic waveform_active,
    input wire logic temp_sensor_active,
    input wire logic busy,
    input wire logic [7:0] source_high_level_one,
    input wire logic [7:0] source_low_level,
    input wire logic [23:0] gate_driver_output_setup
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // busy tracks engine activity one clock late
    property p_wave; waveform_active |=> busy; endproperty
    a_wave: assert property (p_wave) else $error("busy");
    property p_temp; temp_sensor_active |=> busy; endproperty
    a_temp: assert property (p_temp) else $error("busy");
    property p_idle;
        (!waveform_active && !temp_sensor_active)[*2] |-> !busy;
    endproperty
    a_idle: assert property (p_idle) else $error("busy");
    // reset values, checked while reset is low too
    property p_rst;
        disable iff (1'b0) !resetn |=> source_high_level_one == 8'h41
            && source_low_level == 8'h32;
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_grst;
        disable iff (1'b0) !resetn |=> gate_driver_output_setup == 24'h0;
    endproperty
    a_grst: assert property (p_grst) else $error("reset");
    property p_msb; source_low_level[7] == 1'b0; endproperty
    a_msb: assert property (p_msb) else $error("low msb");
    // high level one and gate outputs may not move while nobody is selected
    property p_quiet;
        (cs_n && hw_reset_n)[*8] |-> $stable(source_high_level_one)
            && $stable(gate_driver_output_setup);
    endproperty
    a_quiet: assert property (p_quiet) else $error("moved");
    property p_hw;
        (!hw_reset_n)[*5] |-> source_high_level_one == 8'h41;
    endproperty
    a_hw: assert property (p_hw) else $error("hw reset");
    c_frame: cover property (!cs_n ##1 cs_n);
    c_wave: cover property (waveform_active);
    c_hw: cover property ((!hw_reset_n)[*5]);
endmodule
bind ehc_top ehc_top_sva i_ehc_top_sva (.clk(clk), .resetn(resetn),
    .hw_reset_n(hw_reset_n), .cs_n(cs_n),
    .waveform_active(waveform_active),
    .temp_sensor_active(temp_sensor_active), .busy(busy),
    .source_high_level_one(source_high_level_one),
    .source_low_level(source_low_level),
    .gate_driver_output_setup(gate_driver_output_setup));
`default_nettype wire

/* File: dv/ehc_top_bench.sv */
// Purpose: directed bench for the serial command port
// Assumes: host model makes all serial pin traffic; the bench drives hw reset and strap
// Notes: clk_en held high throughout
`timescale 1ns/1ps
`default_nettype none
module ehc_top_bench;
    import ehc_pkg::*;
    logic clk = 0, resetn = 0, hw_reset_n = 1, strap = 0;
    logic wave = 0, temp = 0, busy, cs_n, dc_sel, sclk, sdata;
    logic [7:0] hi1, hi2, lo, glev;
    logic [23:0] gout;
    int mismatches = 0, check_count = 0, cycles = 0;
    always #25 clk = ~clk;
    ehc_top i_ehc_top (.clk(clk), .resetn(resetn), .clk_en(1'b1),
        .hw_reset_n(hw_reset_n), .cs_n(cs_n), .dc_sel(dc_sel), .sclk(sclk),
        .sdata(sdata), .serial_width_strap(strap), .waveform_active(wave),
        .temp_sensor_active(temp), .busy(busy), .source_high_level_one(hi1),
        .source_high_level_two(hi2), .source_low_level(lo),
        .gate_driver_output_setup(gout), .gate_high_level_select(glev));
    ehc_host_model i_ehc_host_model (.clk(clk), .strap(strap), .busy(busy),
        .cs_n(cs_n), .dc_sel(dc_sel), .sclk(sclk), .sdata(sdata));
    task automatic check(input string s, input logic [31:0] v, e);
        check_count++;
        if (v !== e) begin
            mismatches++;
            $display("unexpected %s exp %h seen %h", s, e, v);
        end
    endtask
    task automatic src(input logic [7:0] a, b, c);
        check("hi1", hi1, a);
        check("hi2", hi2, b);
        check("lo", lo, c);
    endtask
    task automatic tx(input logic d, input logic [7:0] b, input int m = 0);
        i_ehc_host_model.send(d, b, m);
    endtask
    task automatic print_verdict;
        if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // run takes about 1300 cycles; ceiling leaves ample room
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            print_verdict;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1;
        repeat (4) @(posedge clk);
        src(8'h41, 8'ha8, 8'h32);
        check("gate", {glev, gout}, 32'h0);
        tx(0, CMD_SOURCE_LEVEL);
        tx(1, 8'h5a);
        tx(1, 8'h23);
        tx(1, 8'hff);
        tx(1, 8'h11);
        src(8'h5a, 8'h23, 8'h7f);
        tx(0, CMD_GATE_DRV_OUT);
        tx(1, 8'h12);
        tx(1, 8'h34);
        tx(1, 8'h56);
        tx(0, CMD_GATE_LEVEL);
        tx(1, 8'h0f);
        tx(1, CMD_SOURCE_LEVEL);
        tx(1, 8'h99);
        check("gate", {glev, gout}, 32'h0f563412);
        src(8'h5a, 8'h23, 8'h7f);
        tx(0, CMD_SOURCE_LEVEL);
        tx(1, 8'hc3, 1);
        tx(1, 8'h77, 2);
        tx(1, 8'h66);
        check("hi1", hi1, 8'h66);
        // the model reads the strap when a send starts; let it settle
        strap <= 1;
        repeat (3) @(posedge clk);
        tx(0, CMD_SOURCE_LEVEL);
        tx(1, 8'h2a);
        check("hi1", hi1, 8'h2a);
        wave <= 1;
        repeat (3) @(posedge clk);
        check("busy", busy, 1);
        wave <= 0;
        temp <= 1;
        repeat (3) @(posedge clk);
        check("busy", busy, 1);
        temp <= 0;
        repeat (3) @(posedge clk);
        check("busy", busy, 0);
        hw_reset_n <= 0;
        repeat (5) @(posedge clk);
        hw_reset_n <= 1;
        repeat (5) @(posedge clk);
        src(8'h41, 8'ha8, 8'h32);
        tx(0, CMD_SOURCE_LEVEL);
        tx(1, 8'h01);
        resetn <= 0;
        repeat (2) @(posedge clk);
        resetn <= 1;
        repeat (2) @(posedge clk);
        check("hi1", hi1, 8'h41);
        print_verdict;
    end
endmodule
`default_nettype wire
